// *** design/crie_pkg.sv ***
/*
 * crie_pkg: shared constants and carriers for the receive interrupt enable
 * block. Assumes nothing; every design file refers to it by scoped name.
 */
package crie_pkg;
    // register map on the plain register port (index per byte address)
    localparam logic [3:0] ADDR_RX_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_RX_IRQ_EN = 4'h1;
    localparam logic [3:0] ADDR_CTRL = 4'h2;
    localparam logic [3:0] ADDR_ERR_CNT = 4'h3;
    localparam int ADDR_W = 4;

    // enable register field positions
    localparam int EN_WAKE = 7;
    localparam int EN_STATUS = 6;
    localparam int EN_RXSENS_HI = 5;
    localparam int EN_RXSENS_LO = 4;
    localparam int EN_TXSENS_HI = 3;
    localparam int EN_TXSENS_LO = 2;
    localparam int EN_OVERRUN = 1;
    localparam int EN_RXFULL = 0;

    // flag register field positions
    localparam int FL_WAKE = 7;
    localparam int FL_STATUS = 6;
    localparam int FL_RXST_HI = 5;
    localparam int FL_RXST_LO = 4;
    localparam int FL_TXST_HI = 3;
    localparam int FL_TXST_LO = 2;
    localparam int FL_OVERRUN = 1;
    localparam int FL_RXFULL = 0;

    // control register field positions
    localparam int CT_WAKE_EN = 0;

    // reset values
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [1:0] SENS_RESET = 2'h0;

    // error counter thresholds
    localparam logic [8:0] CNT_WARN = 9'h060;    // 96
    localparam logic [8:0] CNT_PASSIVE = 9'h080; // 128
    localparam logic [8:0] CNT_BUSOFF = 9'h100;  // 256

    // bus state codes, shared by receiver and transmitter
    typedef enum logic [1:0] {
        CRIE_ST_OK = 2'b00,
        CRIE_ST_WARN = 2'b01,
        CRIE_ST_PASSIVE = 2'b10,
        CRIE_ST_BUSOFF = 2'b11
    } crie_state_t;

    // sensitivity levels
    typedef enum logic [1:0] {
        CRIE_SENS_NONE = 2'b00,
        CRIE_SENS_BUSOFF = 2'b01,
        CRIE_SENS_PASSIVE = 2'b10,
        CRIE_SENS_ALL = 2'b11
    } crie_sens_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } crie_reg_req_t;

    // interrupt request lines
    typedef struct packed {
        logic wake;
        logic error;
        logic rx;
    } crie_irq_t;
endpackage

// *** design/crie_sens_filter.sv ***
/*
 * crie_sens_filter: decides whether a state change counts as a status
 * change at the chosen sensitivity. Assumes old and new are valid codes.
 */
`timescale 1ns/1ps
module crie_sens_filter (
    input wire logic [1:0] i_sens,
    input wire logic [1:0] i_old,
    input wire logic [1:0] i_new,
    output logic o_hit
);
    logic old_bo;
    logic new_bo;
    logic old_pe;
    logic new_pe;

    // bus-off is 11; passive-or-worse has the top bit set
    always_comb begin
        old_bo = (i_old == crie_pkg::CRIE_ST_BUSOFF);
        new_bo = (i_new == crie_pkg::CRIE_ST_BUSOFF);
        old_pe = i_old[1];
        new_pe = i_new[1];
        unique case (crie_pkg::crie_sens_t'(i_sens))
            crie_pkg::CRIE_SENS_NONE: o_hit = 1'b0;
            crie_pkg::CRIE_SENS_BUSOFF: o_hit = old_bo != new_bo;
            crie_pkg::CRIE_SENS_PASSIVE: o_hit = (old_bo != new_bo) ||
                                                 (old_pe != new_pe);
            crie_pkg::CRIE_SENS_ALL: o_hit = i_old != i_new;
        endcase
    end
endmodule

// *** design/crie_state_enc.sv ***
/*
 * crie_state_enc: turns a 9-bit error count into a bus state code.
 * Assumes the count saturates at or above 256 when bus-off is reached.
 */
`timescale 1ns/1ps
module crie_state_enc (
    input wire logic [8:0] i_count,
    input wire logic i_busoff,
    output crie_pkg::crie_state_t o_state
);
    // thresholds 96, 128, 256; a forced bus-off from outside wins
    always_comb begin
        if (i_busoff || i_count >= crie_pkg::CNT_BUSOFF) begin
            o_state = crie_pkg::CRIE_ST_BUSOFF;
        end else if (i_count >= crie_pkg::CNT_PASSIVE) begin
            o_state = crie_pkg::CRIE_ST_PASSIVE;
        end else if (i_count >= crie_pkg::CNT_WARN) begin
            o_state = crie_pkg::CRIE_ST_WARN;
        end else begin
            o_state = crie_pkg::CRIE_ST_OK;
        end
    end
endmodule

// *** design/crie_top.sv ***
/*
 * crie_top: receive-side interrupt enables, receive flags and bus state
 * tracking for a CAN controller.
 * Assumes: one clock i_clk_sys at 200 MHz; the register master keeps strobes
 * one cycle long and never both at once; events come from logic on the same
 * clock; the bus activity line comes from a pin and is synchronised here.
 */
// Implementation choices: the address-and-strobe port and the placing of the registers.
// Notes on behaviour
// - enables read any time and take writes only outside init mode.
// - in init mode (request and acknowledge set) enable bits 7-6 and 1-0 are held at reset.
// - the two sensitivity fields keep their value through init mode.
// - bit 7 gates the wake flag onto the wake interrupt request.
// - bit 6 gates the status change flag onto the error interrupt request.
// - bits 5-4 pick receiver sensitivity: none, bus-off, passive, all.
// - bits 3-2 pick transmitter sensitivity with the same four levels.
// - state flags show the real state, updated only with no change pending.
// - bit 1 gates the overrun flag onto the error interrupt request.
// - bit 0 gates the receive full flag onto the receiver request.
// - state code 00 below 96, 01 to 127, 10 to 255, 11 from 256 up; the receiver gets 11 only on transmitter bus-off.
// - a pending status change flag freezes the state flags until cleared.
// - bus activity in sleep with wake control set sets the wake flag.
`timescale 1ns/1ps
module crie_top (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_init_request,
    input wire logic i_init_acknowledge,
    input wire logic i_sleep,
    input wire logic i_bus_activity,
    input wire logic i_overrun_evt,
    input wire logic i_rx_full_evt,
    input wire logic [8:0] i_rx_err_cnt,
    input wire logic [8:0] i_tx_err_cnt,
    output logic o_wake_irq,
    output logic o_error_irq,
    output logic o_rx_irq,
    output logic o_rx_full_flag
);
    logic rst_meta_b;
    logic rst_b;
    logic act_meta;
    logic act_sync;
    logic init_mode;
    crie_pkg::crie_reg_req_t req;
    crie_pkg::crie_irq_t irq;
    logic [7:0] en;
    logic [1:0] rx_sens;
    logic [1:0] tx_sens;
    logic wake_enable_ctl;
    logic wake_flag;
    logic status_change_flag;
    logic overrun_flag;
    logic rx_full_flag;
    logic [1:0] rx_state_flags;
    logic [1:0] tx_state_flags;
    crie_pkg::crie_state_t rx_now;
    crie_pkg::crie_state_t tx_now;
    logic tx_busoff;
    logic rx_hit;
    logic tx_hit;
    logic [7:0] clr;
    logic [7:0] flags_rd;
    logic [8:0] rx_cnt_lim;

    // one decode for every register write so the address checks agree
    function automatic logic wr_to(crie_pkg::crie_reg_req_t r,
                                   logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign init_mode = i_init_request && i_init_acknowledge;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    // bus activity arrives from the pin, so two flops before use
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            act_meta <= 1'b0;
            act_sync <= 1'b0;
        end else begin
            act_meta <= i_bus_activity;
            act_sync <= act_meta;
        end
    end

    // enable bits other than the sensitivity fields
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            en <= crie_pkg::EN_RESET;
        end else if (init_mode) begin
            en <= crie_pkg::EN_RESET;
        end else if (wr_to(req, crie_pkg::ADDR_RX_IRQ_EN)) begin
            en <= req.wdata;
        end
    end

    // sensitivity fields survive init mode so a status policy is kept
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_sens <= crie_pkg::SENS_RESET;
            tx_sens <= crie_pkg::SENS_RESET;
        end else if (!init_mode && wr_to(req, crie_pkg::ADDR_RX_IRQ_EN)) begin
            rx_sens <= req.wdata[crie_pkg::EN_RXSENS_HI:crie_pkg::EN_RXSENS_LO];
            tx_sens <= req.wdata[crie_pkg::EN_TXSENS_HI:crie_pkg::EN_TXSENS_LO];
        end
    end

    // wake enable control lives in its own small register
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wake_enable_ctl <= 1'b0;
        end else if (wr_to(req, crie_pkg::ADDR_CTRL)) begin
            wake_enable_ctl <= req.wdata[crie_pkg::CT_WAKE_EN];
        end
    end

    // write one to clear on the flag register
    assign clr = (wr_to(req, crie_pkg::ADDR_RX_FLAGS) && !init_mode) ?
                 req.wdata : 8'h00;

    // error counts to state codes
    assign tx_busoff = (i_tx_err_cnt >= crie_pkg::CNT_BUSOFF);

    // a receiver count past 255 still means passive; only a transmitter
    // bus-off gives the receiver code 11
    assign rx_cnt_lim = (i_rx_err_cnt >= crie_pkg::CNT_BUSOFF) ?
                        (crie_pkg::CNT_BUSOFF - 9'h001) : i_rx_err_cnt;

    crie_state_enc u_rx_enc (
        .i_count(rx_cnt_lim),
        .i_busoff(tx_busoff),
        .o_state(rx_now)
    );

    crie_state_enc u_tx_enc (
        .i_count(i_tx_err_cnt),
        .i_busoff(1'b0),
        .o_state(tx_now)
    );

    // a change counts only at the chosen sensitivity
    crie_sens_filter u_rx_filt (
        .i_sens(rx_sens),
        .i_old(rx_state_flags),
        .i_new(rx_now),
        .o_hit(rx_hit)
    );

    crie_sens_filter u_tx_filt (
        .i_sens(tx_sens),
        .i_old(tx_state_flags),
        .i_new(tx_now),
        .o_hit(tx_hit)
    );

    // state flags track the real state only while nothing is pending;
    // the flag sets in the same edge so the change it reports is frozen
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_state_flags <= crie_pkg::CRIE_ST_OK;
            tx_state_flags <= crie_pkg::CRIE_ST_OK;
        end else if (!status_change_flag) begin
            rx_state_flags <= rx_now;
            tx_state_flags <= tx_now;
        end
    end

    // status change flag; a clear wins while it is set, and a hit still standing sets it again on the next edge
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_change_flag <= 1'b0;
        end else if (!status_change_flag && (rx_hit || tx_hit)) begin
            status_change_flag <= 1'b1;
        end else if (clr[crie_pkg::FL_STATUS]) begin
            status_change_flag <= 1'b0;
        end
    end

    // wake flag from bus activity while asleep
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wake_flag <= 1'b0;
        end else if (i_sleep && wake_enable_ctl && act_sync) begin
            wake_flag <= 1'b1;
        end else if (clr[crie_pkg::FL_WAKE]) begin
            wake_flag <= 1'b0;
        end
    end

    // overrun and receive full flags, set beats clear
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            overrun_flag <= 1'b0;
            rx_full_flag <= 1'b0;
        end else begin
            if (i_overrun_evt) begin
                overrun_flag <= 1'b1;
            end else if (clr[crie_pkg::FL_OVERRUN]) begin
                overrun_flag <= 1'b0;
            end
            if (i_rx_full_evt) begin
                rx_full_flag <= 1'b1;
            end else if (clr[crie_pkg::FL_RXFULL]) begin
                rx_full_flag <= 1'b0;
            end
        end
    end

    // requests are flag and enable, combinational so they drop at once
    always_comb begin
        irq.wake = wake_flag && en[crie_pkg::EN_WAKE];
        irq.error = (status_change_flag && en[crie_pkg::EN_STATUS]) ||
                    (overrun_flag && en[crie_pkg::EN_OVERRUN]);
        irq.rx = rx_full_flag && en[crie_pkg::EN_RXFULL];
    end

    assign o_wake_irq = irq.wake;
    assign o_error_irq = irq.error;
    assign o_rx_irq = irq.rx;
    assign o_rx_full_flag = rx_full_flag; // lets software gate buffer reads

    assign flags_rd = {wake_flag, status_change_flag, rx_state_flags,
                       tx_state_flags, overrun_flag, rx_full_flag};

    // read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge i_clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            o_rdata <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                crie_pkg::ADDR_RX_FLAGS: o_rdata <= flags_rd;
                crie_pkg::ADDR_RX_IRQ_EN: o_rdata <= {en[7:6], rx_sens,
                                                      tx_sens, en[1:0]};
                crie_pkg::ADDR_CTRL: o_rdata <= {7'h00, wake_enable_ctl};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // enable bits 7-6 and 1-0 return to zero while init mode stands
    a_init_hold: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        init_mode |=> (en[7:6] == 2'b00 && en[1:0] == 2'b00))
        else $error("enable bits not held in init mode");

    // write blocked in init mode; sensitivity unchanged
    a_sens_keep: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        init_mode |=> $stable(rx_sens) && $stable(tx_sens))
        else $error("sensitivity changed during init mode");

    // a write outside init mode lands in the enable register
    a_write_takes: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        (req.wr && req.addr == crie_pkg::ADDR_RX_IRQ_EN && !init_mode)
        |=> en == $past(req.wdata))
        else $error("enable write lost");

    // wake request follows flag and enable
    a_wake_req: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        o_wake_irq == (wake_flag && en[7]))
        else $error("wake request mismatch");

    // error request covers status change and overrun
    a_error_req: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        o_error_irq == ((status_change_flag && en[6]) ||
                        (overrun_flag && en[1])))
        else $error("error request mismatch");

    // frozen state flags while status change pending
    a_state_frozen: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        status_change_flag && $past(status_change_flag)
        |-> $stable(rx_state_flags) && $stable(tx_state_flags))
        else $error("state flags moved while change pending");

    // transmitter state flags track the encoded state when nothing pends
    a_state_track: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        !status_change_flag |=> tx_state_flags == $past(tx_now))
        else $error("tx state flags not tracking");

    // receiver state flags track the same way
    a_rx_track: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        !status_change_flag |=> rx_state_flags == $past(rx_now))
        else $error("rx state flags not tracking");

    // bus-off transmitter count gives state 11
    a_busoff_code: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        i_tx_err_cnt >= 9'h100 |-> tx_now == 2'b11)
        else $error("bus-off not encoded");

    sequence s_wake_seen;
        i_sleep && wake_enable_ctl && act_sync;
    endsequence

    // activity in sleep sets wake flag next edge
    a_wake_set: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        s_wake_seen |=> wake_flag)
        else $error("wake flag not set");

    // receive full request
    a_rx_req: assert property (@(posedge i_clk_sys) disable iff (!rst_b)
        i_rx_full_evt && en[0] && !init_mode &&
        !wr_to(req, crie_pkg::ADDR_RX_IRQ_EN) |=> o_rx_irq)
        else $error("receive request missing");
endmodule

// *** verif/crie_bus_model.sv ***
/*
 * crie_bus_model: stands in for the other nodes on the CAN bus, giving
 * error counts, bus activity and receive events on the system clock.
 * Assumes the bench sets its targets just after a rising edge.
 */
`timescale 1ns/1ps
module crie_bus_model (
    input wire logic i_clk,
    input wire logic [8:0] i_rx_set,
    input wire logic [8:0] i_tx_set,
    input wire logic i_act_set,
    input wire logic i_ovr_set,
    input wire logic i_full_set,
    output logic [8:0] o_rx_cnt,
    output logic [8:0] o_tx_cnt,
    output logic o_act,
    output logic o_ovr,
    output logic o_full
);
    // counts jump to the target; the block only sees levels, so the path
    // between two targets is not modelled
    always @(posedge i_clk) begin
        o_rx_cnt <= i_rx_set;
        o_tx_cnt <= i_tx_set;
        o_act <= i_act_set;
        o_ovr <= i_ovr_set;
        o_full <= i_full_set;
    end
endmodule

// *** verif/test_can_rx_interrupt_enable.sv ***
/*
 * test_can_rx_interrupt_enable: self-checking bench for crie_top, with a
 * reference model of enables, flags and requests kept in the bench.
 * Assumes the bus model file and the design package are compiled first.
 */
`timescale 1ns/1ps
module test_can_rx_interrupt_enable;
    logic clk, rst_b, wr, rd, init_rq, init_ak, sleep;
    logic act_set, ovr_set, full_set, act, ovr, full;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v, m_en;
    logic [8:0] rx_set, tx_set, rx_cnt, tx_cnt;
    logic wake_irq, err_irq, rx_irq, full_flag;
    logic m_wk, m_st, m_ov, m_rf, m_ctl;
    logic [1:0] m_rs, m_ts;
    int n_mismatch, comparisons, seed, rxc, txc;
    int rt[5] = '{0, 96, 128, 127, 0};
    int tt[5] = '{0, 127, 255, 256, 0};

    crie_bus_model bus (.i_clk(clk), .i_rx_set(rx_set), .i_tx_set(tx_set),
        .i_act_set(act_set), .i_ovr_set(ovr_set), .i_full_set(full_set),
        .o_rx_cnt(rx_cnt), .o_tx_cnt(tx_cnt), .o_act(act), .o_ovr(ovr),
        .o_full(full));
    crie_top dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_init_request(init_rq), .i_init_acknowledge(init_ak),
        .i_sleep(sleep), .i_bus_activity(act), .i_overrun_evt(ovr),
        .i_rx_full_evt(full), .i_rx_err_cnt(rx_cnt), .i_tx_err_cnt(tx_cnt),
        .o_wake_irq(wake_irq), .o_error_irq(err_irq), .o_rx_irq(rx_irq),
        .o_rx_full_flag(full_flag));

    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // state code of a count; transmitter bus-off drags the receiver too
    function automatic logic [1:0] enc(int c);
        return (txc >= 256) ? 2'h3 : (c >= 128) ? 2'h2 :
               (c >= 96) ? 2'h1 : 2'h0;
    endfunction

    function automatic logic hit(logic [1:0] s, logic [1:0] o, logic [1:0] n);
        if (o == n) return 1'b0;
        case (s)
            2'h1: return (o == 2'h3) != (n == 2'h3);
            2'h2: return (o[1] != n[1]) || ((o == 2'h3) != (n == 2'h3));
            2'h3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // state flags follow the counts only while no status change is pending
    task automatic upd;
        logic [1:0] nr, nt;
        nr = enc(rxc);
        nt = enc(txc);
        if (!m_st) begin
            if (hit(m_en[5:4], m_rs, nr) | hit(m_en[3:2], m_ts, nt)) begin
                m_st = 1'b1;
            end
            m_rs = nr;
            m_ts = nt;
        end
    endtask

    // one write cycle; the model follows unless initialization refuses it
    task automatic wr_reg(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        if (!(init_rq && init_ak)) begin
            if (a == crie_pkg::ADDR_RX_IRQ_EN) m_en = d;
            if (a == crie_pkg::ADDR_RX_FLAGS) begin
                {m_wk, m_st, m_ov, m_rf} &= ~{d[7:6], d[1:0]};
            end
            if (a == crie_pkg::ADDR_CTRL) m_ctl = d[0];
        end
        upd;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic check_all;
        rd_reg(crie_pkg::ADDR_RX_FLAGS, v);
        chk("flags", v, {m_wk, m_st, m_rs, m_ts, m_ov, m_rf});
        rd_reg(crie_pkg::ADDR_RX_IRQ_EN, v);
        chk("enable", v, m_en);
        rd_reg(crie_pkg::ADDR_CTRL, v);
        chk("ctrl", v, {7'h00, m_ctl});
        chk("irq", {4'h0, wake_irq, err_irq, rx_irq, full_flag},
            {4'h0, m_wk & m_en[7], (m_st & m_en[6]) | (m_ov & m_en[1]),
            m_rf & m_en[0], m_rf});
    endtask

    // watchdog against a hang anywhere in the sequence
    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        final_report;
    end

    initial begin
        {rst_b, wr, rd, init_rq, init_ak, sleep, act_set, ovr_set} = '0;
        {full_set, addr, wdata, rx_set, tx_set} = '0;
        {m_wk, m_st, m_ov, m_rf, m_ctl, m_rs, m_ts, rxc, txc} = '0;
        m_en = crie_pkg::EN_RESET;
        seed = 73523;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check_all;
        wr_reg(4'h3, 8'hFF);
        rd_reg(4'h3, v);
        chk("unmapped", v, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(crie_pkg::ADDR_RX_IRQ_EN, 8'($random(seed)));
            check_all;
        end
        // initialization: enables drop, sensitivities stay, writes refused
        wr_reg(crie_pkg::ADDR_RX_IRQ_EN, 8'hFF);
        // a pending overrun must survive a clear written during init
        ovr_set <= 1'b1;
        @(posedge clk);
        ovr_set <= 1'b0;
        m_ov = 1'b1;
        @(posedge clk);
        init_rq <= 1'b1;
        init_ak <= 1'b1;
        m_en &= 8'h3C;
        wr_reg(crie_pkg::ADDR_RX_IRQ_EN, 8'hC3);
        wr_reg(crie_pkg::ADDR_RX_FLAGS, 8'hC3);
        rd_reg(crie_pkg::ADDR_RX_IRQ_EN, v);
        chk("init_enable", v, m_en);
        init_rq <= 1'b0;
        init_ak <= 1'b0;
        check_all;
        // overrun and receive full events under random enables
        for (int i = 0; i < 4; i++) begin
            wr_reg(crie_pkg::ADDR_RX_IRQ_EN, 8'($random(seed)));
            ovr_set <= i[0];
            full_set <= i[1];
            @(posedge clk);
            {ovr_set, full_set} <= 2'b00;
            m_ov |= i[0];
            m_rf |= i[1];
            repeat (3) @(posedge clk);
            check_all;
            wr_reg(crie_pkg::ADDR_RX_FLAGS, 8'hC3);
            check_all;
        end
        // wake needs both sleep and the wake control bit
        wr_reg(crie_pkg::ADDR_RX_IRQ_EN, 8'h80);
        for (int i = 1; i < 4; i++) begin
            wr_reg(crie_pkg::ADDR_CTRL, {7'h00, i[0]});
            sleep <= i[1];
            act_set <= 1'b1;
            repeat (3) @(posedge clk);
            act_set <= 1'b0;
            repeat (4) @(posedge clk);
            m_wk |= i[0] & i[1];
            check_all;
        end
        wr_reg(crie_pkg::ADDR_RX_FLAGS, 8'h80);
        sleep <= 1'b0;
        check_all;
        // every sensitivity on each side; odd steps leave the flag pending
        for (int s = 0; s < 4; s++) begin
            for (int side = 0; side < 2; side++) begin
                wr_reg(crie_pkg::ADDR_RX_IRQ_EN,
                    8'(8'h40 | (side ? s << 2 : s << 4)));
                for (int k = 1; k < 5; k++) begin
                    rxc = side ? 0 : rt[k];
                    txc = side ? tt[k] : 0;
                    rx_set <= 9'(rxc);
                    tx_set <= 9'(txc);
                    repeat (4) @(posedge clk);
                    upd;
                    check_all;
                    if (k % 2 == 0) wr_reg(crie_pkg::ADDR_RX_FLAGS, 8'h40);
                end
            end
        end
        check_all;
        final_report;
    end
endmodule
